/* logic/emx_pkg.sv */
/*
 package for the external memory expansion bus: register addresses, reset values,
 field positions, size codes, cycle states and the request carrier.
 assumes one 125 MHz core clock and a core that reaches registers by plain memory accesses.
*/
// How it works
// [RULE_01] accesses outside rom, ram, registers go external; code sends out only the 256-byte window or the 16-byte area
// [RULE_02] rom up to 48 KB adds 256-byte window
// [RULE_03] 60 KB rom: only 16-byte register-space area
// [RULE_04] port 4 is address/data, port 6 strobes
// [RULE_05] mode 000 single-chip, 01x expansion, else prohibited
// [RULE_06] software writes zero to mode bits 7..3
// [RULE_07] mode register resets to 00, write-only
// [RULE_08] wait register resets to 10H
// [RULE_09] wait 00 none, 01 one, 11 pin
// [RULE_10] software makes wait pin input first
// [RULE_11] wait pin stays port unless pin-wait selected
// [RULE_12] size register resets to CFH
// [RULE_13] rom codes 4,6,8,C,F give 16..60 KB
// [RULE_14] ram code 110 only, 1024 bytes
// [RULE_15] ram field 7..5, rom 3..0, bit4 zero
// [RULE_16] window sits right above configured rom size
// [RULE_17] flash part uses 48 KB or less
// [RULE_18] software sets size to real capacity
// [RULE_19] read strobe only for external reads, fetches
// [RULE_20] write strobe only for external writes
// [RULE_21] wait input ignored on internal accesses
// [RULE_22] address strobe pulses on every cycle
// [RULE_23] address phase first, then data under strobe
// [RULE_24] memory holds wait low until data ready
package emx_pkg;
    // register addresses on the core memory bus
    localparam logic [15:0] MODE_ADDR    = 16'hFF47;
    localparam logic [15:0] SIZE_ADDR    = 16'hFFF0;
    localparam logic [15:0] WAITSET_ADDR = 16'hFF48;
    // 16-byte external area inside register space, base page bits
    localparam logic [11:0] SFR_EXT_BASE = 12'hFFD;
    // area boundaries
    localparam logic [15:0] RAM_BASE     = 16'hFB00;
    localparam logic [15:0] SFR_BASE     = 16'hFF00;
    // reset values
    localparam logic [7:0]  MODE_RST     = 8'h00;
    localparam logic [7:0]  WAITSET_RST  = 8'h10;
    localparam logic [7:0]  SIZE_RST     = 8'hCF;
    // field positions
    localparam int          SIZE_ZERO_BIT = 4;
    // rom size codes, the page just above each rom up to 48 KB, and the ram code
    localparam logic [3:0]  ROM_16K = 4'h4;
    localparam logic [3:0]  ROM_24K = 4'h6;
    localparam logic [3:0]  ROM_32K = 4'h8;
    localparam logic [3:0]  ROM_48K = 4'hC;
    localparam logic [3:0]  ROM_60K = 4'hF;
    localparam logic [7:0]  TOP_16K = 8'h40;
    localparam logic [7:0]  TOP_24K = 8'h60;
    localparam logic [7:0]  TOP_32K = 8'h80;
    localparam logic [7:0]  TOP_48K = 8'hC0;
    localparam logic [2:0]  RAM_1K  = 3'h6;
    // mode and wait encodings
    localparam logic [1:0]  MODE_EXP_HI = 2'h1;
    localparam logic [2:0]  MODE_SINGLE = 3'h0;
    localparam logic [1:0]  WAIT_NONE   = 2'h0;
    localparam logic [1:0]  WAIT_ONE    = 2'h1;
    localparam logic [1:0]  WAIT_PIN    = 2'h3;

    // bus cycle phases
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_STRB = 3'b010,
        ST_WT1  = 3'b011,
        ST_DONE = 3'b100
    } emx_state_e;

    // one core access
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } emx_req_s;
endpackage

/* logic/emx_bus.sv */
/*
 external memory expansion bus controller: mode, wait and size registers,
 address decode of the external window, multiplexed bus cycle and pin sharing.
 assumes the core holds a request until it is taken and internal memories answer elsewhere.
*/
`timescale 1ns/1ns
module emx_bus (
    // clock and reset
    input  wire logic             CLK_SYS,
    input  wire logic             RESETN,
    // core access port
    input  wire logic             CPU_REQ,
    input  wire emx_pkg::emx_req_s CPU_CMD,
    output logic                  CPU_RDY,
    output logic                  CPU_ACK,
    output logic [7:0]            CPU_RDATA,
    output logic                  CPU_EXT,
    // port logic values used in port mode
    input  wire logic [7:0]       PORT4_DO,
    input  wire logic [7:0]       PORT4_OE,
    input  wire logic [3:0]       PORT6_DO,
    input  wire logic [3:0]       PORT6_OE,
    // port 4 pins
    input  wire logic [7:0]       P4_IN,
    output logic [7:0]            P4_OUT,
    output logic [7:0]            P4_OE,
    // port 6 lines 4..7 pins
    input  wire logic [3:0]       P6U_IN,
    output logic [3:0]            P6U_OUT,
    output logic [3:0]            P6U_OE
);
    logic                 rst_meta_ff;  // reset release stage one
    logic                 rst_n_ff;     // reset release stage two
    logic [2:0]           mode_ff;      // expansion mode field
    logic [7:0]           waitset_ff;   // wait setting register
    logic [7:0]           size_ff;      // memory size register
    emx_pkg::emx_state_e  state_ff;     // bus cycle phase
    emx_pkg::emx_state_e  nxt_state;    // next phase
    emx_pkg::emx_req_s    cyc_ff;       // access being run
    logic                 ext_ff;       // access goes to external bus
    logic [7:0]           rdata_ff;     // read data to core
    logic                 ext_en;       // expansion mode active
    logic [1:0]           wsel;         // wait control field
    logic [7:0]           top_page;     // page above configured rom
    logic                 rom_ok;       // rom code is a legal window code
    logic                 hit_ext;      // request address is external
    logic                 take;         // request accepted this cycle
    logic                 strobe;       // strobe phase
    logic                 wait_n;       // wait input as seen by the cycle
    logic                 ad_oe;        // bus drives address/data
    logic [7:0]           ad_out;       // address/data value
    logic                 address_latch_strobe; // address strobe level
    logic                 rd_n;         // read strobe
    logic                 wr_n;         // write strobe

    // reset release through two flops
    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // register field views
    assign ext_en = (mode_ff[2:1] == emx_pkg::MODE_EXP_HI);   // [RULE_05]
    assign wsel   = waitset_ff[1:0];
    assign take   = CPU_REQ && (state_ff == emx_pkg::ST_IDLE);

    // page above the configured rom, independent of the real rom
    always_comb begin
        rom_ok = 1'b1;
        unique case (size_ff[3:0])                                   // [RULE_13]
            emx_pkg::ROM_16K: top_page = emx_pkg::TOP_16K;           // [RULE_16]
            emx_pkg::ROM_24K: top_page = emx_pkg::TOP_24K;
            emx_pkg::ROM_32K: top_page = emx_pkg::TOP_32K;
            emx_pkg::ROM_48K: top_page = emx_pkg::TOP_48K;           // [RULE_02]
            default: begin
                // 60 KB and prohibited codes open no 256-byte window
                top_page = 8'h00;
                rom_ok   = 1'b0;
            end
        endcase
    end

    // external address decode
    always_comb begin
        hit_ext = 1'b0;
        if (ext_en && size_ff[7:5] == emx_pkg::RAM_1K) begin         // [RULE_14]
            if (rom_ok) begin
                // 256 bytes right above rom; all else is internal or reserved
                hit_ext = (CPU_CMD.addr[15:8] == top_page);         // [RULE_01]
            end else if (size_ff[3:0] == emx_pkg::ROM_60K) begin
                // only the 16-byte area inside register space
                hit_ext = (CPU_CMD.addr[15:4] == emx_pkg::SFR_EXT_BASE); // [RULE_03]
            end
        end
    end

    // mode register, write-only, upper bits dropped
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            mode_ff <= emx_pkg::MODE_RST[2:0];                       // [RULE_07]
        end else if (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::MODE_ADDR) begin
            mode_ff <= CPU_CMD.wdata[2:0];
        end
    end

    // wait setting register
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            waitset_ff <= emx_pkg::WAITSET_RST;                      // [RULE_08]
        end else if (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::WAITSET_ADDR) begin
            waitset_ff <= CPU_CMD.wdata;
        end
    end

    // memory size register, bit 4 held at zero
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            size_ff <= emx_pkg::SIZE_RST;                            // [RULE_12]
        end else if (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::SIZE_ADDR) begin
            size_ff <= {CPU_CMD.wdata[7:5], 1'b0, CPU_CMD.wdata[3:0]}; // [RULE_15]
        end
    end

    // cycle capture
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            cyc_ff <= '0;
            ext_ff <= 1'b0;
        end else if (take) begin
            cyc_ff <= CPU_CMD;
            ext_ff <= hit_ext;
        end
    end

    // wait input only counts for external cycles in pin-wait mode
    assign wait_n = !(ext_ff && wsel == emx_pkg::WAIT_PIN) || P6U_IN[2]; // [RULE_21]

    // cycle sequencing: address, strobe, optional waits, done
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            emx_pkg::ST_IDLE: if (CPU_REQ) nxt_state = emx_pkg::ST_ADDR;
            emx_pkg::ST_ADDR: nxt_state = emx_pkg::ST_STRB;          // [RULE_23]
            emx_pkg::ST_STRB: begin
                if (ext_ff && wsel == emx_pkg::WAIT_ONE) begin       // [RULE_09]
                    nxt_state = emx_pkg::ST_WT1;
                end else if (!wait_n) begin
                    nxt_state = emx_pkg::ST_STRB;                    // [RULE_24]
                end else begin
                    nxt_state = emx_pkg::ST_DONE;
                end
            end
            emx_pkg::ST_WT1:  nxt_state = emx_pkg::ST_DONE;
            emx_pkg::ST_DONE: nxt_state = emx_pkg::ST_IDLE;
            default:          nxt_state = emx_pkg::ST_IDLE;
        endcase
    end

    // phase register
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff <= emx_pkg::ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // read data: registers on take, external bus at strobe end
    always_ff @(posedge CLK_SYS or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 8'h00;
        end else if (take) begin
            if (CPU_CMD.addr == emx_pkg::SIZE_ADDR) begin
                rdata_ff <= size_ff;
            end else if (CPU_CMD.addr == emx_pkg::WAITSET_ADDR) begin
                rdata_ff <= waitset_ff;
            end else begin
                // write-only mode register and others read zero
                rdata_ff <= 8'h00;
            end
        end else if (strobe && nxt_state == emx_pkg::ST_DONE && ext_ff && cyc_ff.rd) begin
            rdata_ff <= P4_IN;                                       // [RULE_23]
        end
    end

    // bus phase decode
    assign strobe = (state_ff == emx_pkg::ST_STRB) || (state_ff == emx_pkg::ST_WT1);
    assign address_latch_strobe = (state_ff == emx_pkg::ST_ADDR);    // [RULE_22]
    assign rd_n   = !(strobe && ext_ff && cyc_ff.rd);                // [RULE_19]
    assign wr_n   = !(strobe && ext_ff && cyc_ff.wr);                // [RULE_20]
    assign ad_oe  = address_latch_strobe || (strobe && cyc_ff.wr);
    assign ad_out = address_latch_strobe ? cyc_ff.addr[7:0] : cyc_ff.wdata;

    // pin sharing between bus and ports
    always_comb begin
        P4_OUT  = ext_en ? ad_out : PORT4_DO;                        // [RULE_04]
        P4_OE   = ext_en ? {8{ad_oe}} : PORT4_OE;
        P6U_OUT = PORT6_DO;
        P6U_OE  = PORT6_OE;
        if (ext_en) begin
            P6U_OUT[0] = rd_n;                                       // [RULE_04]
            P6U_OUT[1] = wr_n;
            P6U_OUT[3] = address_latch_strobe;
            P6U_OE[0]  = 1'b1;
            P6U_OE[1]  = 1'b1;
            P6U_OE[3]  = 1'b1;
        end
        // wait pin stays a port pin unless pin-wait is used
        if (ext_en && wsel == emx_pkg::WAIT_PIN) begin               // [RULE_11]
            P6U_OUT[2] = 1'b0;
            P6U_OE[2]  = 1'b0;
        end
    end

    // core handshake
    assign CPU_RDY   = (state_ff == emx_pkg::ST_IDLE);
    assign CPU_ACK   = (state_ff == emx_pkg::ST_DONE);
    assign CPU_RDATA = rdata_ff;
    assign CPU_EXT   = ext_ff;

    // strobe phase steps
    sequence strobe_begin_s;
        $rose(strobe);
    endsequence
    sequence strobe_end_s;
        strobe ##1 !strobe;
    endsequence

    // checks
    rd_internal_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_19]
        (strobe && !ext_ff) |-> rd_n && wr_n)
        else $error("strobe active on internal access");
    wr_only_write_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_20]
        !wr_n |-> (ext_ff && cyc_ff.wr && !cyc_ff.rd))
        else $error("write strobe without external write");
    addr_strobe_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_22]
        take |=> address_latch_strobe ##1 !address_latch_strobe)
        else $error("address strobe missing after request");
    no_wait_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_09]
        (strobe_begin_s and (wsel == emx_pkg::WAIT_NONE)) |-> strobe_end_s)
        else $error("no-wait strobe not one cycle");
    one_wait_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_09]
        (strobe_begin_s and (ext_ff && wsel == emx_pkg::WAIT_ONE)) |-> strobe[*2] ##1 !strobe)
        else $error("one-wait strobe not two cycles");
    pin_wait_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_24]
        (state_ff == emx_pkg::ST_STRB && ext_ff && wsel == emx_pkg::WAIT_PIN && !P6U_IN[2])
        |=> state_ff == emx_pkg::ST_STRB)
        else $error("strobe not stretched by wait pin");
    internal_time_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_21]
        (take && !hit_ext) |-> ##3 CPU_ACK)
        else $error("internal access not done in three cycles");
    single_chip_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_05]
        (mode_ff == emx_pkg::MODE_SINGLE) |-> (P4_OUT == PORT4_DO && P6U_OE == PORT6_OE))
        else $error("pins not in port mode in single-chip mode");
    size_zero_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_15]
        $changed(size_ff) |-> !size_ff[emx_pkg::SIZE_ZERO_BIT])
        else $error("size register bit 4 set");
    read_data_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_23]
        (strobe && nxt_state == emx_pkg::ST_DONE && ext_ff && cyc_ff.rd)
        |=> CPU_ACK && CPU_RDATA == $past(P4_IN))
        else $error("external read data not returned");

    // register write and read checks, acknowledge pulse check
    mode_write_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_07]
        (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::MODE_ADDR)
        |=> mode_ff == $past(CPU_CMD.wdata[2:0]))
        else $error("mode register write lost");
    mode_read_zero_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_07]
        (take && CPU_CMD.addr == emx_pkg::MODE_ADDR) |=> CPU_RDATA == 8'h00)
        else $error("write-only mode register read back");
    size_write_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_15]
        (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::SIZE_ADDR)
        |=> size_ff[7:5] == $past(CPU_CMD.wdata[7:5])
            && size_ff[3:0] == $past(CPU_CMD.wdata[3:0]))
        else $error("size register write lost");
    wait_write_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_09]
        (take && CPU_CMD.wr && CPU_CMD.addr == emx_pkg::WAITSET_ADDR)
        |=> waitset_ff == $past(CPU_CMD.wdata))
        else $error("wait register write lost");
    ack_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_23]
        CPU_ACK |=> !CPU_ACK && CPU_RDY)
        else $error("acknowledge longer than one cycle");

    // window decode checks
    window_gate_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_14]
        hit_ext |-> ext_en && size_ff[7:5] == emx_pkg::RAM_1K)
        else $error("external hit outside expansion setup");
    window_page_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_16]
        (hit_ext && size_ff[3:0] == emx_pkg::ROM_16K)
        |-> CPU_CMD.addr[15:8] == emx_pkg::TOP_16K)
        else $error("16 KB window not above rom");
    small_area_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_03]
        (hit_ext && size_ff[3:0] == emx_pkg::ROM_60K)
        |-> CPU_CMD.addr[15:8] == emx_pkg::SFR_BASE[15:8])
        else $error("60 KB setting hit outside register page");
    no_ram_hit_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_01]
        hit_ext |-> (CPU_CMD.addr < emx_pkg::RAM_BASE || CPU_CMD.addr >= emx_pkg::SFR_BASE))
        else $error("external hit inside internal ram");

    // pin sharing checks
    bus_pins_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_04]
        ext_en |-> P6U_OE[0] && P6U_OE[1] && P6U_OE[3] && P6U_OUT[3] == address_latch_strobe)
        else $error("expansion pins not given to the bus");
    wait_port_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_11]
        !(ext_en && wsel == emx_pkg::WAIT_PIN)
        |-> P6U_OE[2] == PORT6_OE[2] && P6U_OUT[2] == PORT6_DO[2])
        else $error("wait pin taken from the port");
    wait_input_a: assert property (@(posedge CLK_SYS) disable iff (!rst_n_ff) // [RULE_11]
        (ext_en && wsel == emx_pkg::WAIT_PIN) |-> !P6U_OE[2])
        else $error("wait pin driven in pin-wait mode");
endmodule

/* sim/emx_sram_model.sv */
/*
 static ram model on the far side of the multiplexed expansion bus.
 assumes the bench resolves the shared lines and feeds wait_len from its scenarios.
*/
`timescale 1ns/1ns
module emx_sram_model (
    // clock and strobes
    input  wire logic       clk,
    input  wire logic       address_latch_strobe,
    input  wire logic       rd_n,
    input  wire logic       wr_n,
    // multiplexed lines
    input  wire logic [7:0] ad_out,
    output logic      [7:0] ad_in,
    // wait pin, active low
    input  wire logic [31:0] wait_len,
    output logic            wait_n
);
    logic [7:0] mem_ff [256];   // storage, keyed by low address
    logic [7:0] adr_ff;         // latched low address
    logic [7:0] last_ff = 8'h00; // last value put on the lines
    int         cnt_ff = 0;     // cycles of the current strobe
    // latch address, store writes, count strobe cycles
    always_ff @(posedge clk) begin
        if (address_latch_strobe) adr_ff <= ad_out; // address phase
        if (!wr_n) mem_ff[adr_ff] <= ad_out; // data under write strobe
        if (!rd_n) last_ff <= mem_ff[adr_ff];
        cnt_ff <= (!rd_n || !wr_n) ? cnt_ff + 1 : 0;
    end
    // released lines show the inverse, never a stale copy
    assign ad_in  = !rd_n ? mem_ff[adr_ff] : ~last_ff;
    // hold wait low until data is ready
    assign wait_n = !((!rd_n || !wr_n) && cnt_ff < wait_len);
endmodule

/* sim/test_external_memory_expansion_bus.sv */
/*
 self-checking bench for the expansion bus controller with a ram model.
 assumes emx_pkg is compiled first and the design answers within 40 cycles.
*/
`timescale 1ns/1ns
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
module test_external_memory_expansion_bus;
    logic              clk_sys = 1'b0;
    logic              rst_n = 1'b0;
    logic              cpu_req = 1'b0;
    emx_pkg::emx_req_s cpu_cmd = '0;
    logic              cpu_rdy, cpu_ack, cpu_ext, wait_n, hold_low = 1'b0, exp_mode = 1'b0;
    logic [7:0]        cpu_rdata, p4_out, p4_oe, p4_in, mem_ad, q, d;
    logic [7:0]        port4_do = 8'h00, port4_oe = 8'h00, ref_mem [256];
    logic [3:0]        port6_do = 4'h3, port6_oe = 4'hF, p6u_out, p6u_oe, p6u_in;
    logic [15:0]       a;
    logic [31:0]       seed = 32'hEBF0;
    logic [3:0]        codes [4] = '{4'h4, 4'h6, 4'h8, 4'hC};
    logic [7:0]        tops [4] = '{8'h40, 8'h60, 8'h80, 8'hC0};
    logic [1:0]        wcs [3] = '{2'h0, 2'h1, 2'h3};
    int                err_count = 0, samples_checked = 0, wait_len = 0, wcode = 0;
    // wired lines: driver wins, else the ram or the wait pin
    assign p4_in  = (p4_oe & p4_out) | (~p4_oe & mem_ad);
    assign p6u_in = {p6u_out[3], (p6u_oe[2] ? p6u_out[2] : wait_n & !hold_low), p6u_out[1:0]};
    emx_bus i_emx_bus (.CLK_SYS(clk_sys), .RESETN(rst_n), .CPU_REQ(cpu_req), .CPU_CMD(cpu_cmd),
        .CPU_RDY(cpu_rdy), .CPU_ACK(cpu_ack), .CPU_RDATA(cpu_rdata), .CPU_EXT(cpu_ext),
        .PORT4_DO(port4_do), .PORT4_OE(port4_oe), .PORT6_DO(port6_do), .PORT6_OE(port6_oe),
        .P4_IN(p4_in), .P4_OUT(p4_out), .P4_OE(p4_oe), .P6U_IN(p6u_in), .P6U_OUT(p6u_out),
        .P6U_OE(p6u_oe));
    emx_sram_model i_emx_sram_model (.clk(clk_sys), .address_latch_strobe(p6u_out[3]),
        .rd_n(p6u_out[0]), .wr_n(p6u_out[1]), .ad_out(p4_out), .ad_in(mem_ad),
        .wait_len(wait_len),
        .wait_n(wait_n));
    // xorshift source of random values
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction
    // verdict and end of run
    task report_and_stop;
        if (err_count == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one core access with strobe watch and latency check
    task automatic acc(input logic [15:0] ad, input logic [7:0] wd, input logic w,
                       input logic ext, output logic [7:0] r);
        int   n, e;
        logic sr, sw, sa, ak;
        n = 0;
        sr = 1'b0;
        sw = 1'b0;
        sa = 1'b0;
        e = (ext && wcode == 1) ? 4 : (ext && wcode == 3) ? 3 + wait_len : 3;
        @(posedge clk_sys);
        cpu_req <= 1'b1;
        cpu_cmd <= '{addr: ad, wdata: wd, rd: !w, wr: w};
        @(posedge clk_sys);
        cpu_req <= 1'b0;
        do begin
            // first look falls in the address phase right after the take edge
            #1;
            n++;
            ak = cpu_ack;
            if (p6u_out[3] === 1'b1) sa = 1'b1;
            if (p6u_out[3] === 1'b1 && ext) `CHK(p4_out, ad[7:0])
            if (p6u_out[1] === 1'b0) sw = 1'b1;
            if (p6u_out[1] === 1'b0) `CHK(p4_out, wd)
            if (p6u_out[0] === 1'b0) sr = 1'b1;
            // step to the next cycle unless the answer stands now
            if (ak !== 1'b1 && n < 40) @(posedge clk_sys);
        end while (ak !== 1'b1 && n < 40);
        if (ak !== 1'b1) begin
            err_count++;
            $display("CHECK FAILED t=%0t no acknowledge", $time);
            report_and_stop();
        end
        r = cpu_rdata;
        `CHK(n, e)
        `CHK(cpu_ext, ext)
        `CHK(sr, ext & !w)
        `CHK(sw, ext & w)
        `CHK(sa, exp_mode)
    endtask
    // clock
    initial forever #4 clk_sys = ~clk_sys;
    // main sequence
    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        seed = xs(seed);
        port4_do <= seed[7:0];
        port4_oe <= seed[15:8];
        @(posedge clk_sys);
        #1;
        `CHK({p4_out, p4_oe, p6u_out}, {port4_do, port4_oe, port6_do})
        acc(emx_pkg::SIZE_ADDR, 8'h00, 1'b0, 1'b0, q);
        `CHK(q, 8'hCF)
        acc(emx_pkg::WAITSET_ADDR, 8'h00, 1'b0, 1'b0, q);
        `CHK(q, 8'h10)
        acc(emx_pkg::MODE_ADDR, 8'h00, 1'b0, 1'b0, q);
        `CHK(q, 8'h00)
        acc(16'h4000, 8'h5A, 1'b1, 1'b0, q);
        acc(emx_pkg::SIZE_ADDR, 8'hD4, 1'b1, 1'b0, q);
        acc(emx_pkg::SIZE_ADDR, 8'h00, 1'b0, 1'b0, q);
        `CHK(q, 8'hC4)
        for (int i = 0; i < 4; i++) begin
            acc(emx_pkg::SIZE_ADDR, {4'hC, codes[i]}, 1'b1, 1'b0, q);
            // the mode write already runs its address phase in expansion mode
            exp_mode = 1'b1;
            acc(emx_pkg::MODE_ADDR, {7'h01, i[0]}, 1'b1, 1'b0, q);
            `CHK({p6u_oe, p6u_out[1:0]}, 6'h3F)
            for (int k = 0; k < 2; k++) begin
                seed = xs(seed);
                a = {tops[i], seed[7:0]};
                ref_mem[a[7:0]] = seed[15:8];
                acc(a, seed[15:8], 1'b1, 1'b1, q);
                acc(a, 8'h00, 1'b0, 1'b1, q);
                `CHK(q, ref_mem[a[7:0]])
            end
            acc({tops[i] - 8'h01, 8'hFF}, 8'h00, 1'b0, 1'b0, q);
            acc({tops[i] + 8'h01, 8'h00}, 8'h00, 1'b0, 1'b0, q);
        end
        acc(16'hFB00, 8'h00, 1'b0, 1'b0, q);
        acc(emx_pkg::SIZE_ADDR, 8'hCF, 1'b1, 1'b0, q);
        acc(16'hC000, 8'h00, 1'b0, 1'b0, q);
        acc(16'hFFD5, 8'hA7, 1'b1, 1'b1, q);
        acc(16'hFFD5, 8'h00, 1'b0, 1'b1, q);
        `CHK(q, 8'hA7)
        acc(emx_pkg::SIZE_ADDR, 8'hC5, 1'b1, 1'b0, q);
        acc(16'h4000, 8'h00, 1'b0, 1'b0, q);
        acc(emx_pkg::SIZE_ADDR, 8'hA4, 1'b1, 1'b0, q);
        acc(16'h4000, 8'h00, 1'b0, 1'b0, q);
        acc(emx_pkg::SIZE_ADDR, 8'hC4, 1'b1, 1'b0, q);
        exp_mode = 1'b0;
        acc(emx_pkg::MODE_ADDR, 8'h04, 1'b1, 1'b0, q);
        acc(16'h4000, 8'h00, 1'b0, 1'b0, q);
        exp_mode = 1'b1;
        acc(emx_pkg::MODE_ADDR, 8'h02, 1'b1, 1'b0, q);
        for (int j = 0; j < 3; j++) begin
            // wait pin becomes an input only before pin-wait is chosen
            if (wcs[j] == 2'h3) port6_oe <= 4'hB;
            acc(emx_pkg::WAITSET_ADDR, {6'h04, wcs[j]}, 1'b1, 1'b0, q);
            wcode = wcs[j];
            wait_len = 2 + j;
            #1;
            `CHK(p6u_oe[2], (wcs[j] == 2'h3) ? 1'b0 : port6_oe[2])
            seed = xs(seed);
            d = seed[7:0];
            acc(16'h40C3, d, 1'b1, 1'b1, q);
            acc(16'h40C3, 8'h00, 1'b0, 1'b1, q);
            `CHK(q, d)
        end
        hold_low = 1'b1;
        acc(16'hFB10, 8'h00, 1'b0, 1'b0, q);
        hold_low = 1'b0;
        report_and_stop();
    end
endmodule
